// *** src/burst_cfg_pkg.sv ***
// Purpose: shared constants for the synchronous burst read sequencer
// Assumes: 100 MHz system clock, 16-bit words, 23-bit word address
// Notes: configuration field positions, reset value and codes
package burst_cfg_pkg;
  localparam int ADDR_W = 23;
  localparam int DATA_W = 16;
  localparam int CFG_W = 16;
  localparam int FIFO_DEPTH = 8;
  localparam int BOUND_BITS = 4;
  localparam int CLK_PERIOD_NS = 10;
  localparam int INIT_TIME_NS = 1000;
  localparam int INIT_CYCLES = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [CFG_W-1:0] CFG_RESET = 16'h3DDF;
  localparam int CFG_LAT_MSB = 13;
  localparam int CFG_LAT_LSB = 11;
  localparam int CFG_POL = 10;
  localparam int CFG_HOLD = 9;
  localparam int CFG_WTIME = 8;
  localparam int CFG_ORDER = 7;
  localparam int CFG_EDGE = 6;
  localparam int CFG_PINF = 4;
  localparam int CFG_WRAP = 3;
  localparam int CFG_LEN_MSB = 2;
  localparam int CFG_LEN_LSB = 0;
  localparam logic [2:0] LEN_4 = 3'h1;
  localparam logic [2:0] LEN_8 = 3'h2;
  localparam logic [2:0] LEN_16 = 3'h3;
  localparam logic [2:0] LAT_MIN = 3'h2;
  localparam logic [2:0] CNT_ONE = 3'h1;
  localparam logic [4:0] WORDS_4 = 5'h04;
  localparam logic [4:0] WORDS_8 = 5'h08;
  localparam logic [4:0] WORDS_16 = 5'h10;
  localparam logic [4:0] WORD_ONE = 5'h01;
  localparam logic [ADDR_W-1:0] MASK_4 = 23'h00_0003;
  localparam logic [ADDR_W-1:0] MASK_8 = 23'h00_0007;
  localparam logic [ADDR_W-1:0] MASK_16 = 23'h00_000F;
  localparam logic [BOUND_BITS-1:0] BOUND_ZERO = 4'h0;
  typedef enum logic [2:0] {S_IDLE, S_LAT, S_DATA, S_BWAIT, S_END} seq_state_t;
  typedef enum logic [1:0] {F_LOW, F_HIGH, F_DIP} first_address_latch_sequence_state_t;
endpackage

// *** src/burst_read_sequencer.sv ***
// Purpose: configuration-driven synchronous burst read sequencer
// Assumes: read clock, enables and address arrive as pins; array answers i_arr_valid
// Notes: pins pass two flops; output timing is in sampled read-clock edges
`timescale 1ns/1ns
module burst_read_sequencer
  import burst_cfg_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_clk_k,
  input wire logic i_latch_n,
  input wire logic i_chip_en_n,
  input wire logic i_out_en_n,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic i_rw_in,
  output logic o_rw_out,
  output logic o_rw_oe,
  output logic [DATA_W-1:0] o_data,
  output logic o_data_valid,
  output logic o_data_oe,
  input wire logic i_cfg_we,
  input wire logic [CFG_W-1:0] i_cfg_wdata,
  output logic [CFG_W-1:0] o_cfg_rdata,
  output logic o_arr_req,
  output logic [ADDR_W-1:0] o_arr_addr,
  input wire logic i_arr_valid,
  input wire logic [DATA_W-1:0] i_arr_data,
  output logic o_first_address_latch_sequence_restart
);
  function automatic logic [ADDR_W-1:0] step_addr(input logic [ADDR_W-1:0] a, input logic wrap,
                                                  input logic [ADDR_W-1:0] m);
    logic [ADDR_W-1:0] inc;
    inc = a + 1'b1;
    step_addr = wrap ? ((a & ~m) | (inc & m)) : inc;
  endfunction

  // address bits settle while latch is low, so skew between bits is harmless
  logic [ADDR_W+4:0] pins_s;
  logic k_s, latch_n_s, chip_n_s, oe_n_s, rw_in_s;
  logic [ADDR_W-1:0] addr_s;
  pin_sync #(.WIDTH(ADDR_W + 5)) u_sync (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_pin({i_clk_k, i_latch_n, i_chip_en_n, i_out_en_n, i_rw_in, i_addr}),
    .o_sync(pins_s)
  );
  assign {k_s, latch_n_s, chip_n_s, oe_n_s, rw_in_s, addr_s} = pins_s;

  logic [CFG_W-1:0] cfg_reg, act_cfg_reg, act_cfg_next;
  seq_state_t state_reg, state_next;
  first_address_latch_sequence_state_t first_address_latch_sequence_reg;
  logic [2:0] cnt_reg, cnt_next;
  logic [4:0] words_reg, words_next;
  logic [ADDR_W-1:0] out_addr_reg, out_addr_next;
  logic [1:0] bwait_reg, bwait_next;
  logic [DATA_W-1:0] data_reg, data_next;
  logic hold_reg, hold_next, valid_reg, valid_next, ahead_reg, ahead_next;
  logic bdone_reg, bdone_next, first_reg, first_next;
  logic k_d_reg, rw_out_reg, rw_oe_reg, data_oe_reg, first_address_latch_sequence_pulse_reg;
  logic [$clog2(INIT_CYCLES+1)-1:0] init_cnt_reg;
  logic fetch_on_reg, pend_reg, arr_req_reg;
  logic [ADDR_W-1:0] fetch_addr_reg, arr_addr_reg;
  logic [4:0] fetch_cnt_reg;
  logic fifo_in_ready, fifo_out_valid, pop;
  logic [DATA_W-1:0] fifo_data;

  // decoded fields: length, wrap and hold from the burst's own configuration snapshot; pin function and latency from live cfg_reg
  logic [2:0] act_len, lat_live;
  logic act_cont, wrap_en, hold2, pinf_live;
  logic [ADDR_W-1:0] act_mask;
  logic [4:0] act_words;
  assign act_len = act_cfg_reg[CFG_LEN_MSB:CFG_LEN_LSB];
  assign act_cont = !(act_len == LEN_4 || act_len == LEN_8 || act_len == LEN_16);
  assign act_mask = (act_len == LEN_4) ? MASK_4 : (act_len == LEN_8) ? MASK_8 : MASK_16;
  assign act_words = (act_len == LEN_4) ? WORDS_4 : (act_len == LEN_8) ? WORDS_8 : WORDS_16;
  assign wrap_en = !act_cfg_reg[CFG_WRAP] && !act_cont;
  assign hold2 = act_cfg_reg[CFG_HOLD];
  assign pinf_live = cfg_reg[CFG_PINF];
  assign lat_live = (cfg_reg[CFG_LAT_MSB:CFG_LAT_LSB] < LAT_MIN) ? LAT_MIN : cfg_reg[CFG_LAT_MSB:CFG_LAT_LSB];

  logic k_edge, init_busy, first_address_latch_sequence_hit, abort, start;
  assign k_edge = cfg_reg[CFG_EDGE] ? (k_s && !k_d_reg) : (!k_s && k_d_reg);
  assign init_busy = init_cnt_reg != '0;
  assign first_address_latch_sequence_hit = pinf_live && !init_busy && first_address_latch_sequence_reg == F_DIP && rw_in_s;
  assign abort = chip_n_s || init_busy || first_address_latch_sequence_hit;
  assign start = k_edge && !abort && state_reg == S_IDLE && !latch_n_s;

  // next presented address; steps wrap within the block when wrap_en is set, otherwise they are consecutive
  logic [ADDR_W-1:0] pres_addr, pres_step;
  logic boundary, la_end, la_bnd;
  assign pres_addr = first_reg ? out_addr_reg : step_addr(out_addr_reg, wrap_en, act_mask);
  assign pres_step = step_addr(pres_addr, wrap_en, act_mask);
  assign boundary = !first_reg && !wrap_en && !bdone_reg && bwait_reg != '0 &&
                    pres_addr[BOUND_BITS-1:0] == BOUND_ZERO;
  assign la_end = !act_cont && (words_reg + WORD_ONE) == act_words;
  assign la_bnd = !wrap_en && !bdone_reg && bwait_reg != '0 && pres_step[BOUND_BITS-1:0] == BOUND_ZERO;

  always_comb
  begin
    logic present;
    present = 1'b0;
    pop = 1'b0;
    state_next = state_reg;
    cnt_next = cnt_reg;
    words_next = words_reg;
    out_addr_next = out_addr_reg;
    bwait_next = bwait_reg;
    data_next = data_reg;
    hold_next = hold_reg;
    valid_next = valid_reg;
    ahead_next = ahead_reg;
    bdone_next = bdone_reg;
    first_next = first_reg;
    act_cfg_next = act_cfg_reg;
    if (abort)
    begin
      state_next = S_IDLE;
      valid_next = 1'b0;
      ahead_next = 1'b0;
    end
    else if (k_edge)
    begin
      unique case (state_reg)
        S_IDLE:
          if (start)
          begin
            act_cfg_next = cfg_reg;
            out_addr_next = addr_s;
            bwait_next = addr_s[1:0];
            bdone_next = 1'b0;
            words_next = '0;
            first_next = 1'b1;
            cnt_next = lat_live;
            state_next = S_LAT;
          end
        S_LAT, S_BWAIT:
          if (cnt_reg <= CNT_ONE)
            present = 1'b1;
          else
            cnt_next = cnt_reg - CNT_ONE;
        S_DATA:
          if (hold_reg)
            hold_next = 1'b0;
          else if (!act_cont && words_reg == act_words)
          begin
            state_next = S_END;
            valid_next = 1'b0;
          end
          else if (boundary)
          begin
            state_next = S_BWAIT;
            cnt_next = {1'b0, bwait_reg};
            bdone_next = 1'b1;
            valid_next = 1'b0;
          end
          else
            present = 1'b1;
        S_END:
          valid_next = 1'b0;
      endcase
    end
    if (present)
    begin
      valid_next = fifo_out_valid;
      if (fifo_out_valid)
      begin
        pop = 1'b1;
        data_next = fifo_data;
        out_addr_next = pres_addr;
        words_next = words_reg + WORD_ONE;
        hold_next = hold2;
        ahead_next = la_end || la_bnd;
        first_next = 1'b0;
        state_next = S_DATA;
      end
    end
  end

  // pin: ready function drives low while busy; wait function follows data validity
  logic wait_on, rw_oe_next, rw_out_next;
  assign wait_on = (state_reg != S_IDLE && !valid_reg) ||
                   (act_cfg_reg[CFG_WTIME] && ahead_reg && valid_reg);
  assign rw_oe_next = pinf_live ? init_busy : !oe_n_s;
  assign rw_out_next = pinf_live ? 1'b0 : (cfg_reg[CFG_POL] ? wait_on : !wait_on);

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      state_reg <= S_IDLE;
      cnt_reg <= '0;
      words_reg <= '0;
      out_addr_reg <= '0;
      bwait_reg <= '0;
      data_reg <= '0;
      hold_reg <= 1'b0;
      valid_reg <= 1'b0;
      ahead_reg <= 1'b0;
      bdone_reg <= 1'b0;
      first_reg <= 1'b0;
      act_cfg_reg <= CFG_RESET;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      words_reg <= words_next;
      out_addr_reg <= out_addr_next;
      bwait_reg <= bwait_next;
      data_reg <= data_next;
      hold_reg <= hold_next;
      valid_reg <= valid_next;
      ahead_reg <= ahead_next;
      bdone_reg <= bdone_next;
      first_reg <= first_next;
      act_cfg_reg <= act_cfg_next;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      cfg_reg <= CFG_RESET;
      k_d_reg <= 1'b0;
      rw_out_reg <= 1'b0;
      rw_oe_reg <= 1'b0;
      data_oe_reg <= 1'b0;
      first_address_latch_sequence_pulse_reg <= 1'b0;
      init_cnt_reg <= INIT_CYCLES[$bits(init_cnt_reg)-1:0];
    end
    else
    begin
      if (i_cfg_we)
        cfg_reg <= i_cfg_wdata;
      k_d_reg <= k_s;
      rw_out_reg <= rw_out_next;
      rw_oe_reg <= rw_oe_next;
      data_oe_reg <= !oe_n_s;
      first_address_latch_sequence_pulse_reg <= first_address_latch_sequence_hit;
      if (init_busy)
        init_cnt_reg <= init_cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      first_address_latch_sequence_reg <= F_LOW;
    else if (!pinf_live || init_busy)
      first_address_latch_sequence_reg <= F_LOW;
    else
      unique case (first_address_latch_sequence_reg)
        F_LOW: if (rw_in_s) first_address_latch_sequence_reg <= F_HIGH;
        F_HIGH: if (!rw_in_s) first_address_latch_sequence_reg <= F_DIP;
        F_DIP: if (rw_in_s) first_address_latch_sequence_reg <= F_HIGH;
      endcase
  end

  // array fetcher runs ahead of the output and fills the FIFO
  logic issue;
  assign issue = fetch_on_reg && !pend_reg && fifo_in_ready && (act_cont || fetch_cnt_reg != act_words);

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      fetch_on_reg <= 1'b0;
      pend_reg <= 1'b0;
      arr_req_reg <= 1'b0;
      fetch_addr_reg <= '0;
      arr_addr_reg <= '0;
      fetch_cnt_reg <= '0;
    end
    else if (abort || start)
    begin
      fetch_on_reg <= start;
      pend_reg <= 1'b0;
      arr_req_reg <= 1'b0;
      fetch_addr_reg <= addr_s;
      fetch_cnt_reg <= '0;
    end
    else
    begin
      arr_req_reg <= issue;
      if (issue)
      begin
        arr_addr_reg <= fetch_addr_reg;
        fetch_addr_reg <= step_addr(fetch_addr_reg, wrap_en, act_mask);
        fetch_cnt_reg <= fetch_cnt_reg + WORD_ONE;
        pend_reg <= 1'b1;
      end
      else if (i_arr_valid)
        pend_reg <= 1'b0;
    end
  end

  word_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_clear(abort || start),
    .i_in_valid(i_arr_valid && pend_reg),
    .o_in_ready(fifo_in_ready),
    .i_in_data(i_arr_data),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(pop),
    .o_out_data(fifo_data)
  );

  assign o_rw_out = rw_out_reg;
  assign o_rw_oe = rw_oe_reg;
  assign o_data = data_reg;
  assign o_data_valid = valid_reg;
  assign o_data_oe = data_oe_reg;
  assign o_cfg_rdata = cfg_reg;
  assign o_arr_req = arr_req_reg;
  assign o_arr_addr = arr_addr_reg;
  assign o_first_address_latch_sequence_restart = first_address_latch_sequence_pulse_reg;

  AST_HOLD_TWO: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (k_edge && !abort && state_reg == S_DATA && valid_reg && hold_reg) |=> (valid_reg && $stable(data_reg)))
    else $error("second hold clock lost the word");
  AST_WAIT_IN_LAT: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (state_reg == S_LAT && !pinf_live && !oe_n_s && $stable(cfg_reg)) |=> (o_rw_oe && o_rw_out == cfg_reg[CFG_POL]))
    else $error("wait not asserted during latency");
  AST_WAIT_EARLY: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (valid_reg && ahead_reg && act_cfg_reg[CFG_WTIME] && !pinf_live && !oe_n_s && $stable(cfg_reg))
    |=> (o_rw_out == cfg_reg[CFG_POL]))
    else $error("early wait missing");
  AST_START_ON_EDGE: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (state_reg == S_IDLE ##1 state_reg == S_LAT) |-> $past(k_edge))
    else $error("burst started off the active edge");
  AST_READY_LOW: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (init_busy && pinf_live) |=> (o_rw_oe && !o_rw_out))
    else $error("pin released before configuration done");
  AST_FIRST_ADDRESS_LATCH_SEQUENCE: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    first_address_latch_sequence_hit |=> (state_reg == S_IDLE && o_first_address_latch_sequence_restart))
    else $error("restart pulse not honoured");
  AST_WRAP_BLOCK: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (pop && wrap_en && !first_reg) |=> ((out_addr_reg & ~act_mask) == $past(out_addr_reg & ~act_mask)))
    else $error("wrapped burst left its block");
  AST_SEQ_STEP: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (pop && !wrap_en && !first_reg) |=> (out_addr_reg == $past(out_addr_reg) + 1'b1))
    else $error("address not consecutive");
  AST_BOUND_WAIT: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (k_edge && !abort && state_reg == S_DATA && !hold_reg && boundary && (act_cont || words_reg != act_words))
    |=> (state_reg == S_BWAIT && !valid_reg && cnt_reg == {1'b0, $past(bwait_reg)}))
    else $error("boundary wait count wrong");
  AST_BOUND_ONCE: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (state_reg == S_DATA ##1 state_reg == S_BWAIT) |-> !$past(bdone_reg))
    else $error("second boundary wait in one burst");
  AST_END_COUNT: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (state_reg == S_END) |-> (!act_cont && words_reg == act_words))
    else $error("burst ended at wrong length");
  AST_CFG_FROZEN: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (state_reg != S_IDLE && !start) |=> $stable(act_cfg_reg))
    else $error("configuration changed mid-burst");
endmodule

// *** src/pin_sync.sv ***
// Purpose: two-flop synchroniser for pin inputs
// Assumes: pins are asynchronous to i_sys_clk
// Notes: first stage is read only by the second stage
`timescale 1ns/1ns
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic [WIDTH-1:0] i_pin,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
    end
    else
    begin
      meta_reg <= i_pin;
      sync_reg <= meta_reg;
    end
  end

  assign o_sync = sync_reg;
endmodule

// *** src/word_fifo.sv ***
// Purpose: prefetch FIFO between array reads and the output sequencer
// Assumes: single clock, synchronous clear
// Notes: o_in_ready stalls the array fetcher when full
`timescale 1ns/1ns
module word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_clear,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0] wr_ptr_reg;
  logic [PW:0] rd_ptr_reg;
  logic push;
  logic pop;
  logic full;
  logic empty;

  assign full = (wr_ptr_reg[PW] != rd_ptr_reg[PW]) && (wr_ptr_reg[PW-1:0] == rd_ptr_reg[PW-1:0]);
  assign empty = wr_ptr_reg == rd_ptr_reg;
  assign push = i_in_valid && !full;
  assign pop = i_out_ready && !empty;
  assign o_in_ready = !full;
  assign o_out_valid = !empty;
  assign o_out_data = mem[rd_ptr_reg[PW-1:0]];

  always_ff @(posedge i_sys_clk)
  begin
    if (push)
      mem[wr_ptr_reg[PW-1:0]] <= i_in_data;
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end
    else if (i_clear)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop)
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end
endmodule

// *** verification/host_model.sv ***
// Purpose: host side of the burst pins: read clock, strobes, address
// Assumes: read clock half period of 5 system cycles, driven at falling i_sys_clk
// Notes: read clock stands low outside frames; address inverted once latched
`timescale 1ns/1ns
module host_model
  import burst_cfg_pkg::*;
(
  input wire logic i_sys_clk,
  output logic o_clk_k,
  output logic o_latch_n,
  output logic o_chip_en_n,
  output logic o_out_en_n,
  output logic [ADDR_W-1:0] o_addr
);
  int cyc = 0;
  int t_latch = 0;

  initial
  begin
    o_clk_k = 1'b0;
    o_latch_n = 1'b1;
    o_chip_en_n = 1'b1;
    o_out_en_n = 1'b1;
    o_addr = '0;
  end

  always @(posedge i_sys_clk)
    cyc <= cyc + 1;

  // one frame: latch on the first active edge, run edges, then abort
  task automatic burst(input logic [ADDR_W-1:0] a, input int edges, input logic rise);
    int n;
    n = 0;
    @(negedge i_sys_clk);
    o_chip_en_n = 1'b0;
    o_out_en_n = 1'b0;
    o_latch_n = 1'b0;
    o_addr = a;
    repeat (6) @(negedge i_sys_clk);
    while (n < edges)
    begin
      repeat (5) @(negedge i_sys_clk);
      o_clk_k = ~o_clk_k;
      if (o_clk_k == rise)
      begin
        if (n == 0)
          t_latch = cyc;
        n++;
      end
      else if (n > 0)
      begin
        o_latch_n = 1'b1;
        o_addr = ~a;
      end
    end
    repeat (5) @(negedge i_sys_clk);
    o_chip_en_n = 1'b1;
    o_out_en_n = 1'b1;
    repeat (5) @(negedge i_sys_clk);
    o_clk_k = 1'b0;
    repeat (10) @(negedge i_sys_clk);
  endtask
endmodule

// *** verification/testbench.sv ***
// Purpose: self-checking bench for the burst read sequencer and its FIFO
// Assumes: array answers one cycle after each request with address-derived data
// Notes: words are timed in system cycles; one read clock period is 10 of them
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fail_count++; $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module testbench
  import burst_cfg_pkg::*;
;
  typedef struct {logic [CFG_W-1:0] cfg; logic [ADDR_W-1:0] st; int n;} row_t;
  localparam logic [ADDR_W-1:0] BASE = 23'h00_0100;
  // order bit set and reserved bits clear in every value
  row_t rows [8] = '{
    '{16'h14D9, 23'h00_000D, 4},
    '{16'h14D1, 23'h00_0003, 4},
    '{16'h1ED2, 23'h00_0007, 8},
    '{16'h24DB, 23'h00_0002, 16},
    '{16'h3CD7, 23'h00_000D, 24},
    '{16'h2E99, 23'h00_0000, 4},
    '{16'h30CA, 23'h00_000C, 8},
    '{16'h1DC9, 23'h00_000E, 4}
  };
  logic i_sys_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic clk_k, latch_n, chip_en_n, out_en_n, rw_wire, o_rw_out, o_rw_oe, o_data_valid;
  logic [ADDR_W-1:0] addr, o_arr_addr;
  logic [DATA_W-1:0] o_data;
  logic tb_rw_low = 1'b0;
  logic i_cfg_we = 1'b0;
  logic [CFG_W-1:0] i_cfg_wdata = '0;
  logic [CFG_W-1:0] o_cfg_rdata;
  logic o_arr_req, o_first_address_latch_sequence_restart, data_oe;
  logic i_arr_valid = 1'b0;
  logic pend = 1'b0;
  logic [DATA_W-1:0] i_arr_data = '0;
  logic lg = 1'b0;
  logic oe_bad = 1'b0;
  int req_cnt = 0;
  int fail_count = 0;
  int checks = 0;
  logic [DATA_W-1:0] q_d [$];
  int q_t [$];
  logic q_rw [$];
  int q_r [$];
  logic pv = 1'b0;
  logic [DATA_W-1:0] pd = '0;

  // pull-up on the ready/wait wire
  assign rw_wire = o_rw_oe ? o_rw_out : !tb_rw_low;
  always #5 i_sys_clk = ~i_sys_clk;

  burst_read_sequencer u_burst_read_sequencer (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_clk_k(clk_k),
    .i_latch_n(latch_n), .i_chip_en_n(chip_en_n), .i_out_en_n(out_en_n), .i_addr(addr), .i_rw_in(rw_wire),
    .o_rw_out(o_rw_out), .o_rw_oe(o_rw_oe), .o_data(o_data), .o_data_valid(o_data_valid), .o_data_oe(data_oe),
    .i_cfg_we(i_cfg_we), .i_cfg_wdata(i_cfg_wdata), .o_cfg_rdata(o_cfg_rdata), .o_arr_req(o_arr_req),
    .o_arr_addr(o_arr_addr), .i_arr_valid(i_arr_valid), .i_arr_data(i_arr_data),
    .o_first_address_latch_sequence_restart(o_first_address_latch_sequence_restart));
  host_model u_host_model (.i_sys_clk(i_sys_clk), .o_clk_k(clk_k), .o_latch_n(latch_n),
    .o_chip_en_n(chip_en_n), .o_out_en_n(out_en_n), .o_addr(addr));

  // array: answer each request one cycle later
  always @(negedge i_sys_clk)
  begin
    i_arr_valid <= pend;
    i_arr_data <= o_arr_addr[15:0] ^ 16'h5A5A;
    pend <= o_arr_req;
  end

  // log each new word, its time, request count, and the settled ready/wait level one cycle on
  always @(negedge i_sys_clk)
  begin
    if (lg)
      q_rw.push_back(o_rw_out);
    lg = 1'b0;
    if (o_arr_req === 1'b1)
      req_cnt++;
    if (o_data_valid === 1'b1 && (!pv || o_data !== pd))
    begin
      q_d.push_back(o_data);
      q_t.push_back(u_host_model.cyc);
      q_r.push_back(req_cnt);
      lg = 1'b1;
      if (data_oe !== 1'b1)
        oe_bad = 1'b1;
    end
    pv = (o_data_valid === 1'b1);
    pd = o_data;
  end

  task automatic give_verdict();
    if (fail_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic do_reset();
    i_rstn = 1'b0;
    repeat (4) @(negedge i_sys_clk);
    i_rstn = 1'b1;
    @(negedge i_sys_clk);
    `CHK(o_cfg_rdata, CFG_RESET)
    repeat (50) @(negedge i_sys_clk);
    `CHK({o_rw_oe, o_rw_out}, 2'b10)
    repeat (60) @(negedge i_sys_clk);
    `CHK(o_rw_oe, 1'b0)
  endtask

  task automatic run_row(input row_t r);
    int h, lat, wn, w, cr, i, d;
    logic [ADDR_W-1:0] s, a;
    logic wr, pol;
    h = r.cfg[CFG_HOLD] ? 2 : 1;
    lat = int'(r.cfg[CFG_LAT_MSB:CFG_LAT_LSB]);
    wn = (r.cfg[2:0] == LEN_4) ? 4 : (r.cfg[2:0] == LEN_8) ? 8 : (r.cfg[2:0] == LEN_16) ? 16 : 0;
    wr = !r.cfg[CFG_WRAP] && wn != 0;
    pol = r.cfg[CFG_POL];
    s = BASE + r.st;
    cr = 0;
    @(negedge i_sys_clk);
    i_cfg_we = 1'b1;
    i_cfg_wdata = r.cfg;
    @(negedge i_sys_clk);
    i_cfg_we = 1'b0;
    `CHK(o_cfg_rdata, r.cfg)
    q_d.delete();
    q_t.delete();
    q_rw.delete();
    q_r.delete();
    req_cnt = 0;
    oe_bad = 1'b0;
    u_host_model.burst(s, lat + r.n * h + 6, r.cfg[CFG_EDGE]);
    `CHK(o_data_valid, 1'b0)
    `CHK(data_oe, 1'b0)
    `CHK(oe_bad, 1'b0)
    `CHK(o_arr_req, 1'b0)
    if (wn != 0)
      `CHK(q_d.size(), r.n)
    else
      `CHK(q_d.size() >= r.n, 1'b1)
    // prefetch stops at the burst length, or once the 8-word buffer is full, long before first data
    `CHK(q_r[0], (wn != 0 && wn < FIFO_DEPTH) ? wn : FIFO_DEPTH)
    if (wn != 0)
      `CHK(req_cnt, wn)
    d = q_t[0] - u_host_model.t_latch;
    `CHK(d >= 10 * lat + 1 && d <= 10 * lat + 5, 1'b1)
    for (i = 0; i < r.n && i < q_d.size(); i++)
    begin
      w = 0;
      if (wr)
        a = (s & ADDR_W'(~(wn - 1))) | ADDR_W'((s + i) & (wn - 1));
      else
        a = s + ADDR_W'(i);
      if (!wr && i > 0 && a[3:0] == 4'h0 && cr == 0)
      begin
        w = int'(s[1:0]);
        cr = 1;
      end
      `CHK(q_d[i], a[15:0] ^ 16'h5A5A)
      `CHK(q_r[i] <= i + 1 + FIFO_DEPTH, 1'b1)
      if (i > 0)
        `CHK(q_t[i] - q_t[i - 1], 10 * (h + w))
      if (i > 0 && !r.cfg[CFG_PINF])
        `CHK(q_rw[i - 1], (r.cfg[CFG_WTIME] && w > 0) ? pol : !pol)
    end
    if (!r.cfg[CFG_PINF])
      `CHK(q_rw[r.n - 1], r.cfg[CFG_WTIME] ? pol : !pol)
  endtask

  initial
  begin
    int i;
    do_reset();
    for (i = 0; i < 8; i++)
      run_row(rows[i]);
    do_reset();
    tb_rw_low = 1'b1;
    repeat (5) @(negedge i_sys_clk);
    tb_rw_low = 1'b0;
    i = 0;
    while (o_first_address_latch_sequence_restart !== 1'b1 && i < 10)
    begin
      @(negedge i_sys_clk);
      i++;
    end
    `CHK(o_first_address_latch_sequence_restart, 1'b1)
    give_verdict();
  end

  initial
  begin
    #500000;
    fail_count++;
    give_verdict();
  end
endmodule
